//--- hw/hcir_regs.sv
// hot-plug command, status and interrupt locator registers
// assumes classic wishbone master, slot logic and command core on clk_i
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps

// Function
// - msi number bits 4:0 reflect multiple message enable bits 6:4
// - programming interface register reads constant 01h
// - target slot bits 12:8 pick slot for slot operations
// - slot and code may be written separately; current slot used
// - target slot ignored for non slot-operation commands
// - target slot reads last written value, kept after completion
// - any write to command code bits 7:0 starts execution
// - command code reads last written value, kept after completion
// - busy bit 0 rises on code write, stays set while executing
// - busy falls when execution finishes, marking completion
// - command register writes discarded while busy
// - only a code write sets busy, never automatic power-down
// - error code bits 3:1 updated as busy falls, zero is success
// - locator bits 7:1 hold per-slot pending on unmasked events
// - clearing a slot's latched events clears its pending bit
// - locator bit 0 is completion detected and not masked
// - completion detected bit 16 set on busy fall, write one clears
// - completion mask bit 2 resets to one, detection still sets
module hcir_regs #(
    parameter int NUM_SLOTS = 7
) (
    input  wire logic                           clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [hcir_pkg::HCIR_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic [2:0]                     multi_msg_enable_i,
    input  wire logic [6:0]                     slot_event_i,
    input  wire hcir_pkg::hcir_done_t           cmd_done_i,
    output hcir_pkg::hcir_cmd_t                 cmd_o,
    output logic      [31:0]                    interrupt_source_locator_o,
    output logic                                irq_o
);
    import hcir_pkg::*;

    if (NUM_SLOTS < 1 || NUM_SLOTS > HCIR_MAX_SLOTS) begin : g_bad_slots
        $error("NUM_SLOTS must be 1 to 7");
    end

    hcir_state_t q;
    hcir_state_t d;

    logic [6:0]  slot_used;
    logic [6:0]  slot_pending;
    logic [31:0] locator;
    logic        req;
    logic        wr_commit;
    logic [7:0]  idx;

    // register index of a byte address; non-word-aligned bits fall away
    function automatic logic [7:0] reg_index(input logic [HCIR_ADR_W-1:0] adr);
        return adr[HCIR_ADR_W-1:2];
    endfunction

    function automatic logic is_slot_op(input logic [7:0] code);
        return (code & HCIR_SLOT_OP_MASK) == HCIR_SLOT_OP_MATCH;
    endfunction

    // slots beyond NUM_SLOTS never latch and never report
    for (genvar g = 0; g < HCIR_MAX_SLOTS; g++) begin : g_slot
        assign slot_used[g] = (g < NUM_SLOTS);
    end

    assign slot_pending = q.slot_lat & ~q.slot_msk & slot_used;

    // combinational so a pending bit drops the cycle its cause goes away
    always_comb begin
        locator      = 32'h0000_0000;
        locator[7:1] = slot_pending;
        locator[0]   = q.ccd & ~q.completion_interrupt_mask;
    end

    assign req       = wb_cyc_i & wb_stb_i;
    assign wr_commit = req & wb_we_i & q.ack;
    assign idx       = reg_index(wb_adr_i);

    always_comb begin
        d       = q;
        d.ack   = req & ~q.ack;
        d.start = 1'b0;

        // read data is captured as the answer is formed
        if (req && !q.ack) begin
            d.rdata = 32'h0000_0000;
            unique case (idx)
                HCIR_IDX_MSI_NUM:  d.rdata[4:0] = {2'b00, multi_msg_enable_i};
                HCIR_IDX_PROG_IF:  d.rdata[7:0] = HCIR_PROG_IF_VAL;
                HCIR_IDX_COMMAND: begin
                    d.rdata[HCIR_CMD_CODE_LSB +: 8] = q.code;
                    d.rdata[HCIR_CMD_SLOT_LSB +: 5] = q.slot;
                end
                HCIR_IDX_CMD_STS: begin
                    d.rdata[HCIR_STS_BUSY]        = (q.st == HCIR_CMD_BUSY);
                    d.rdata[HCIR_STS_ERR_LSB +: 3] = q.err;
                end
                HCIR_IDX_INTERRUPT_SOURCE_LOCATOR:  d.rdata = locator;
                HCIR_IDX_CTRL_EN: begin
                    d.rdata[HCIR_EN_CCD]  = q.ccd;
                    d.rdata[HCIR_EN_COMPLETION_INTERRUPT_MASK] = q.completion_interrupt_mask;
                end
                HCIR_IDX_SLOT_LAT: d.rdata[6:0] = q.slot_lat;
                HCIR_IDX_SLOT_MSK: d.rdata[6:0] = q.slot_msk;
                default:           d.rdata = 32'h0000_0000;
            endcase
        end

        // software writes, taken at the edge where ack is seen high
        if (wr_commit) begin
            unique case (idx)
                HCIR_IDX_COMMAND: begin
                    // busy guard also blocks the slot field: a new slot must
                    // not retarget a command already in flight
                    if (q.st == HCIR_CMD_IDLE) begin
                        if (wb_sel_i[1]) begin
                            d.slot = wb_dat_i[HCIR_CMD_SLOT_LSB +: 5];
                        end
                        if (wb_sel_i[0]) begin
                            d.code  = wb_dat_i[HCIR_CMD_CODE_LSB +: 8];
                            d.start = 1'b1;
                            d.st    = HCIR_CMD_BUSY;
                        end
                    end
                end
                HCIR_IDX_CTRL_EN: begin
                    if (wb_sel_i[2] && wb_dat_i[HCIR_EN_CCD]) begin
                        d.ccd = 1'b0;
                    end
                    if (wb_sel_i[0]) begin
                        d.completion_interrupt_mask = wb_dat_i[HCIR_EN_COMPLETION_INTERRUPT_MASK];
                    end
                end
                HCIR_IDX_SLOT_LAT: begin
                    if (wb_sel_i[0]) begin
                        d.slot_lat = q.slot_lat & ~wb_dat_i[6:0];
                    end
                end
                HCIR_IDX_SLOT_MSK: begin
                    if (wb_sel_i[0]) begin
                        d.slot_msk = wb_dat_i[6:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // hardware sets come last so a set beats a clear in the same cycle
        d.slot_lat = d.slot_lat | (slot_event_i & slot_used);

        unique case (q.st)
            HCIR_CMD_IDLE: begin
            end
            HCIR_CMD_BUSY: begin
                if (cmd_done_i.done && !q.start) begin
                    d.st  = HCIR_CMD_IDLE;
                    d.err = cmd_done_i.err;
                    d.ccd = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q.ack      <= 1'b0;
            q.rdata    <= 32'h0000_0000;
            q.st       <= HCIR_CMD_IDLE;
            q.code     <= 8'h00;
            q.slot     <= 5'h00;
            q.err      <= 3'h0;
            q.start    <= 1'b0;
            q.ccd      <= 1'b0;
            q.completion_interrupt_mask     <= HCIR_COMPLETION_INTERRUPT_MASK_RST;
            q.slot_lat <= 7'h00;
            q.slot_msk <= HCIR_SLOT_MSK_RST;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;

    always_comb begin
        cmd_o.start      = q.start;
        cmd_o.code       = q.code;
        cmd_o.slot_valid = is_slot_op(q.code);
        cmd_o.slot       = is_slot_op(q.code) ? q.slot : 5'h00;
    end

    assign interrupt_source_locator_o = locator;
    assign irq_o                      = |locator;

endmodule // hcir_regs

//--- inc/hcir_pkg.sv
// package for the hot-plug command and interrupt register bank
// assumes a 32-bit classic wishbone slave with word-aligned registers
package hcir_pkg;

    // printed register indices; byte address is four times the index
    localparam logic [7:0] HCIR_IDX_MSI_NUM   = 8'h12;
    localparam logic [7:0] HCIR_IDX_PROG_IF   = 8'h13;
    localparam logic [7:0] HCIR_IDX_COMMAND   = 8'h14;
    localparam logic [7:0] HCIR_IDX_CMD_STS   = 8'h16;
    localparam logic [7:0] HCIR_IDX_INTERRUPT_SOURCE_LOCATOR   = 8'h18;
    localparam logic [7:0] HCIR_IDX_CTRL_EN   = 8'h20;
    localparam logic [7:0] HCIR_IDX_SLOT_LAT  = 8'h24;
    localparam logic [7:0] HCIR_IDX_SLOT_MSK  = 8'h25;
    localparam int         HCIR_ADR_W         = 10;

    // field positions
    localparam int HCIR_CMD_CODE_LSB = 0;
    localparam int HCIR_CMD_SLOT_LSB = 8;
    localparam int HCIR_STS_BUSY     = 0;
    localparam int HCIR_STS_ERR_LSB  = 1;
    localparam int HCIR_EN_COMPLETION_INTERRUPT_MASK      = 2;
    localparam int HCIR_EN_CCD       = 16;
    localparam int HCIR_MAX_SLOTS    = 7;

    // reset values and constants
    localparam logic [7:0] HCIR_PROG_IF_VAL   = 8'h01;
    localparam logic       HCIR_COMPLETION_INTERRUPT_MASK_RST      = 1'b1;
    localparam logic [6:0] HCIR_SLOT_MSK_RST  = 7'h7f;
    // slot-operation commands are those whose code matches under this mask
    localparam logic [7:0] HCIR_SLOT_OP_MASK  = 8'he0;
    localparam logic [7:0] HCIR_SLOT_OP_MATCH = 8'h00;

    typedef enum logic {
        HCIR_CMD_IDLE = 1'b0,
        HCIR_CMD_BUSY = 1'b1
    } hcir_cmd_state_t;

    // command handed to the controller core
    typedef struct packed {
        logic       start;
        logic [7:0] code;
        logic [4:0] slot;
        logic       slot_valid;
    } hcir_cmd_t;

    // completion reported by the controller core
    typedef struct packed {
        logic       done;
        logic [2:0] err;
    } hcir_done_t;

    typedef struct packed {
        logic            ack;
        logic [31:0]     rdata;
        hcir_cmd_state_t st;
        logic [7:0]      code;
        logic [4:0]      slot;
        logic [2:0]      err;
        logic            start;
        logic            ccd;
        logic            completion_interrupt_mask;
        logic [6:0]      slot_lat;
        logic [6:0]      slot_msk;
    } hcir_state_t;

endpackage

//--- bench/hcir_regs_asserts.sv
// port-level checks for the hot-plug command and interrupt register bank
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module hcir_regs_asserts #(
    parameter int NUM_SLOTS = 7
) (
    input wire logic                            clk_i,
    input wire logic                            sys_rst_i,
    input wire logic                            wb_cyc_i,
    input wire logic                            wb_stb_i,
    input wire logic                            wb_we_i,
    input wire logic [hcir_pkg::HCIR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]                      wb_sel_i,
    input wire logic [31:0]                     wb_dat_o,
    input wire logic                            wb_ack_o,
    input wire logic [2:0]                      multi_msg_enable_i,
    input wire hcir_pkg::hcir_done_t            cmd_done_i,
    input wire hcir_pkg::hcir_cmd_t             cmd_o,
    input wire logic [31:0]                     interrupt_source_locator_o,
    input wire logic                            irq_o
);
    import hcir_pkg::*;
    logic        busy_q;
    logic        code_wr;
    logic        rd_ack;
    logic [31:0] loc;
    assign loc     = interrupt_source_locator_o;
    assign rd_ack  = wb_ack_o && !wb_we_i;
    assign code_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == {HCIR_IDX_COMMAND, 2'b00};
    // shadow busy flag, so starts can be judged without a bus read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) busy_q <= 1'b0;
        else if (cmd_o.start) busy_q <= 1'b1;
        else if (cmd_done_i.done) busy_q <= 1'b0;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack1; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_ack1; endproperty
    property p_start; code_wr && !busy_q |=> cmd_o.start; endproperty
    property p_busy; busy_q |-> !cmd_o.start; endproperty
    property p_cc;
        $rose(loc[0]) |-> $past(busy_q && cmd_done_i.done) || $past(wb_ack_o && wb_we_i);
    endproperty
    property p_msi;
        rd_ack && wb_adr_i == {HCIR_IDX_MSI_NUM, 2'b00}
            |-> wb_dat_o == {29'h0, $past(multi_msg_enable_i)};
    endproperty
    property p_prog;
        rd_ack && wb_adr_i == {HCIR_IDX_PROG_IF, 2'b00} |-> wb_dat_o == {24'h0, HCIR_PROG_IF_VAL};
    endproperty
    property p_irq; irq_o == (|loc) && loc[31:8] == 24'h0; endproperty
    property p_slot;
        cmd_o.slot_valid == ((cmd_o.code & HCIR_SLOT_OP_MASK) == HCIR_SLOT_OP_MATCH)
            && (cmd_o.slot_valid || cmd_o.slot == 5'h0);
    endproperty
    a_ack: assert property (p_ack) else $error("ack is not a one-cycle answer");
    a_start: assert property (p_start) else $error("code write gave no start");
    a_busy: assert property (p_busy) else $error("start while busy");
    a_cc: assert property (p_cc) else $error("completion pending without cause");
    a_msi: assert property (p_msi) else $error("msi number mismatch");
    a_prog: assert property (p_prog) else $error("prog interface mismatch");
    a_irq: assert property (p_irq) else $error("irq does not follow locator");
    a_slot: assert property (p_slot) else $error("slot classification wrong");
endmodule // hcir_regs_asserts

bind hcir_regs hcir_regs_asserts #(.NUM_SLOTS(NUM_SLOTS)) hcir_regs_asserts_inst (
    .clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .multi_msg_enable_i, .cmd_done_i, .cmd_o, .interrupt_source_locator_o, .irq_o);

//--- bench/hcir_regs_tb_top.sv
// self-checking bench for the hot-plug command and interrupt registers
// assumes hcir_regs on one 125 MHz clock with a classic wishbone slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module hcir_regs_tb_top;
    import hcir_pkg::*;
    logic                  clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    logic                  wb_cyc_i = 1'b0;
    logic                  wb_stb_i = 1'b0;
    logic                  wb_we_i = 1'b0;
    logic [HCIR_ADR_W-1:0] wb_adr_i = '0;
    logic [3:0]            wb_sel_i = '0;
    logic [31:0]           wb_dat_i = '0;
    logic [31:0]           wb_dat_o, loc;
    logic                  wb_ack_o, irq_o;
    logic [6:0]            slot_event_i = '0;
    logic [2:0]            multi_msg_enable_i = 3'h5;
    hcir_done_t            cmd_done_i = '0;
    hcir_cmd_t             cmd_o, last_cmd;
    int                    n_errors = 0, samples_checked = 0, n_start = 0, cycles = 0;

    hcir_regs #(.NUM_SLOTS(7)) hcir_regs_inst (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .multi_msg_enable_i, .slot_event_i, .cmd_done_i, .cmd_o,
        .interrupt_source_locator_o(loc), .irq_o);

    initial forever #4 clk_i = ~clk_i;

    task automatic test_done();
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // counts start pulses mid-cycle, so the count is settled before the
    // task that issued the command returns at the next rising edge
    always @(negedge clk_i) begin
        cycles++;
        if (cmd_o.start === 1'b1) begin
            n_start++;
            last_cmd = cmd_o;
        end
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic bus(input logic [7:0] idx, input logic we, input logic [3:0] sel,
                       input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string n);
        bus(idx, 1'b0, 4'hf, 32'h0);
        `CHK(n, e, wb_dat_o)
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(HCIR_IDX_PROG_IF, 32'h01, "prog_if");
        rd(HCIR_IDX_MSI_NUM, 32'h05, "msi_num");
        multi_msg_enable_i <= 3'h2;
        @(posedge clk_i);
        rd(HCIR_IDX_MSI_NUM, 32'h02, "msi_num2");
        rd(HCIR_IDX_CTRL_EN, 32'h04, "ctrl_en");
        rd(8'h30, 32'h0, "unmapped");
        bus(HCIR_IDX_COMMAND, 1'b1, 4'h2, 32'h0300);
        rd(HCIR_IDX_COMMAND, 32'h0300, "slot only");
        rd(HCIR_IDX_CMD_STS, 32'h0, "no busy");
        bus(HCIR_IDX_COMMAND, 1'b1, 4'h1, 32'h0005);
        `CHK("start", {n_start, last_cmd}, {32'd1, 1'b1, 8'h05, 5'd3, 1'b1})
        rd(HCIR_IDX_CMD_STS, 32'h1, "busy");
        bus(HCIR_IDX_COMMAND, 1'b1, 4'h3, 32'h0a07);
        rd(HCIR_IDX_COMMAND, 32'h0305, "while busy");
        cmd_done_i <= {1'b1, 3'b101};
        @(posedge clk_i);
        cmd_done_i <= '0;
        @(posedge clk_i);
        rd(HCIR_IDX_CMD_STS, 32'h0a, "err code");
        rd(HCIR_IDX_COMMAND, 32'h0305, "kept");
        rd(HCIR_IDX_CTRL_EN, 32'h10004, "ccd set");
        `CHK("masked", {irq_o, loc}, 33'h0)
        bus(HCIR_IDX_CTRL_EN, 1'b1, 4'h1, 32'h0);
        `CHK("completion_pending", {irq_o, loc}, {1'b1, 32'h1})
        bus(HCIR_IDX_CTRL_EN, 1'b1, 4'h4, 32'h10000);
        `CHK("ccd clr", {irq_o, loc}, 33'h0)
        bus(HCIR_IDX_COMMAND, 1'b1, 4'h3, 32'h0421);
        `CHK("non slot", {n_start, last_cmd}, {32'd2, 1'b1, 8'h21, 5'd0, 1'b0})
        bus(HCIR_IDX_SLOT_MSK, 1'b1, 4'h1, 32'h7c);
        slot_event_i <= 7'h07;
        @(posedge clk_i);
        slot_event_i <= 7'h00;
        @(posedge clk_i);
        `CHK("slot pend", {irq_o, loc}, {1'b1, 32'h06})
        bus(HCIR_IDX_SLOT_LAT, 1'b1, 4'h1, 32'h01);
        `CHK("slot clr", loc, 32'h04)
        bus(HCIR_IDX_SLOT_MSK, 1'b1, 4'h1, 32'h7f);
        `CHK("slot mask", {irq_o, loc}, 33'h0)
        test_done();
    end
endmodule // hcir_regs_tb_top
